// file: core/alb_limit_bank.sv
// Alert limit threshold registers and comparators
`timescale 1ns/10ps
`include "alb_params.svh"
module alb_limit_bank #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`ALB_ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    // Mode bits from configuration
    input wire logic shunt_range_select,
    input wire logic alert_latch_select,
    input wire logic averaged_alert_select,
    // Raw conversion results
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_shunt,
    input wire logic [DATA_W-1:0] raw_bus,
    input wire logic [`ALB_TEMP_W-1:0] raw_die_temp,
    input wire logic [`ALB_PWR_W-1:0] raw_power,
    // Averaged results
    input wire logic avg_valid,
    input wire logic [DATA_W-1:0] avg_shunt,
    input wire logic [DATA_W-1:0] avg_bus,
    input wire logic [`ALB_TEMP_W-1:0] avg_die_temp,
    input wire logic [`ALB_PWR_W-1:0] avg_power,
    // Trim checksum
    input wire logic checksum_error,
    // Flags
    output logic shunt_over_flag,
    output logic shunt_under_flag,
    output logic bus_over_flag,
    output logic bus_under_flag,
    output logic temp_over_flag,
    output logic power_over_flag,
    output logic trim_checksum_ok,
    output logic [DATA_W-1:0] diag_alert_status
);
    logic [DATA_W-1:0] shunt_high_limit_reg;
    logic [DATA_W-1:0] shunt_low_limit_reg;
    logic [`ALB_BUS_W-1:0] bus_high_limit_reg;
    logic [`ALB_BUS_W-1:0] bus_low_limit_reg;
    logic [`ALB_TEMP_W-1:0] temperature_ceiling_reg;
    logic [DATA_W-1:0] power_ceiling_reg;
    logic sel_valid;
    logic [DATA_W-1:0] sel_shunt;
    logic [DATA_W-1:0] sel_bus;
    logic [`ALB_TEMP_W-1:0] sel_temp;
    logic [`ALB_PWR_W-1:0] sel_power;
    logic [DATA_W-1:0] power_top;
    logic diag_read;
    logic [DATA_W-1:0] rdata_next;
    logic wr_shunt_hi;
    logic wr_shunt_lo;
    logic wr_bus_hi;
    logic wr_bus_lo;
    logic wr_temp;
    logic wr_power;

    // Shunt range only scales the LSB weight; thresholds and results share
    // it, so the compare itself needs no change
    // Bus and temperature thresholds use the result scale directly

    // Result source select
    always_comb begin
        if (averaged_alert_select) begin
            sel_valid = avg_valid;
            sel_shunt = avg_shunt;
            sel_bus = avg_bus;
            sel_temp = avg_die_temp;
            sel_power = avg_power;
        end else begin
            sel_valid = raw_valid;
            sel_shunt = raw_shunt;
            sel_bus = raw_bus;
            sel_temp = raw_die_temp;
            sel_power = raw_power;
        end
    end

    // Ceiling LSB weighs 256 result LSBs, so drop the low byte
    assign power_top = sel_power[`ALB_PWR_W-1:`ALB_PWR_SHIFT];

    // Write strobe decode; status and unmapped addresses take no write
    always_comb begin
        wr_shunt_hi = 1'b0;
        wr_shunt_lo = 1'b0;
        wr_bus_hi = 1'b0;
        wr_bus_lo = 1'b0;
        wr_temp = 1'b0;
        wr_power = 1'b0;
        if (reg_wr) begin
            if (reg_addr == `ALB_OFS_SHUNT_HI) begin
                wr_shunt_hi = 1'b1;
            end else if (reg_addr == `ALB_OFS_SHUNT_LO) begin
                wr_shunt_lo = 1'b1;
            end else if (reg_addr == `ALB_OFS_BUS_HI) begin
                wr_bus_hi = 1'b1;
            end else if (reg_addr == `ALB_OFS_BUS_LO) begin
                wr_bus_lo = 1'b1;
            end else if (reg_addr == `ALB_OFS_TEMP) begin
                wr_temp = 1'b1;
            end else if (reg_addr == `ALB_OFS_POWER) begin
                wr_power = 1'b1;
            end
        end
    end

    // Shunt limits keep the full word, sign included
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_high_limit_reg <= `ALB_RST_SHUNT_HI;
        end else if (wr_shunt_hi) begin
            shunt_high_limit_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_low_limit_reg <= `ALB_RST_SHUNT_LO;
        end else if (wr_shunt_lo) begin
            shunt_low_limit_reg <= reg_wdata;
        end
    end

    // Bus limits store 15 bits, so bit 15 of a write is dropped here
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_high_limit_reg <= `ALB_RST_BUS_HI;
        end else if (wr_bus_hi) begin
            bus_high_limit_reg <= reg_wdata[`ALB_BUS_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_low_limit_reg <= `ALB_RST_BUS_LO;
        end else if (wr_bus_lo) begin
            bus_low_limit_reg <= reg_wdata[`ALB_BUS_W-1:0];
        end
    end

    // Temperature limit keeps only the upper field of the word
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            temperature_ceiling_reg <= `ALB_RST_TEMP;
        end else if (wr_temp) begin
            temperature_ceiling_reg <=
                reg_wdata[DATA_W-1:`ALB_TEMP_LSB];
        end
    end

    // Power ceiling holds a plain unsigned word
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_ceiling_reg <= `ALB_RST_POWER;
        end else if (wr_power) begin
            power_ceiling_reg <= reg_wdata;
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        if (reg_addr == `ALB_OFS_DIAG) begin
            rdata_next = diag_alert_status;
        end else if (reg_addr == `ALB_OFS_SHUNT_HI) begin
            rdata_next = shunt_high_limit_reg;
        end else if (reg_addr == `ALB_OFS_SHUNT_LO) begin
            rdata_next = shunt_low_limit_reg;
        end else if (reg_addr == `ALB_OFS_BUS_HI) begin
            rdata_next = {1'b0, bus_high_limit_reg};
        end else if (reg_addr == `ALB_OFS_BUS_LO) begin
            rdata_next = {1'b0, bus_low_limit_reg};
        end else if (reg_addr == `ALB_OFS_TEMP) begin
            rdata_next = {temperature_ceiling_reg,
                          {`ALB_TEMP_LSB{1'b0}}};
        end else if (reg_addr == `ALB_OFS_POWER) begin
            rdata_next = power_ceiling_reg;
        end else begin
            rdata_next = '0;
        end
    end

    // Read data is registered and stands until the next read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    // Only a status read clears, and only flags in latch mode
    assign diag_read = reg_rd && (reg_addr == `ALB_OFS_DIAG);

    // Signed compare: a negative high threshold trips on 0 V
    alb_limit_cmp #(
        .W(DATA_W),
        .SIGNED_CMP(1'b1),
        .DIR(alb_pkg::ALB_CMP_GT)
    ) u_shunt_over (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(sel_valid),
        .sample(sel_shunt),
        .limit(shunt_high_limit_reg),
        .latch_mode(alert_latch_select),
        .clear(diag_read),
        .flag(shunt_over_flag)
    );

    // Ordering of negative thresholds is left to the host; a swapped pair
    // makes both shunt flags fire on one sample
    alb_limit_cmp #(
        .W(DATA_W),
        .SIGNED_CMP(1'b1),
        .DIR(alb_pkg::ALB_CMP_LT)
    ) u_shunt_under (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(sel_valid),
        .sample(sel_shunt),
        .limit(shunt_low_limit_reg),
        .latch_mode(alert_latch_select),
        .clear(diag_read),
        .flag(shunt_under_flag)
    );

    // Bus result is positive; top bit of the result is taken as magnitude
    alb_limit_cmp #(
        .W(DATA_W),
        .SIGNED_CMP(1'b0),
        .DIR(alb_pkg::ALB_CMP_GT)
    ) u_bus_over (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(sel_valid),
        .sample(sel_bus),
        .limit({1'b0, bus_high_limit_reg}),
        .latch_mode(alert_latch_select),
        .clear(diag_read),
        .flag(bus_over_flag)
    );

    // Bus low limit resets to zero, so the under flag stays quiet
    alb_limit_cmp #(
        .W(DATA_W),
        .SIGNED_CMP(1'b0),
        .DIR(alb_pkg::ALB_CMP_LT)
    ) u_bus_under (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(sel_valid),
        .sample(sel_bus),
        .limit({1'b0, bus_low_limit_reg}),
        .latch_mode(alert_latch_select),
        .clear(diag_read),
        .flag(bus_under_flag)
    );

    // Temperature field lines up with the 12-bit die result
    alb_limit_cmp #(
        .W(`ALB_TEMP_W),
        .SIGNED_CMP(1'b1),
        .DIR(alb_pkg::ALB_CMP_GT)
    ) u_temp_over (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(sel_valid),
        .sample(sel_temp),
        .limit(temperature_ceiling_reg),
        .latch_mode(alert_latch_select),
        .clear(diag_read),
        .flag(temp_over_flag)
    );

    // Power compare is unsigned on the upper sixteen result bits
    alb_limit_cmp #(
        .W(DATA_W),
        .SIGNED_CMP(1'b0),
        .DIR(alb_pkg::ALB_CMP_GT)
    ) u_power_over (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(sel_valid),
        .sample(power_top),
        .limit(power_ceiling_reg),
        .latch_mode(alert_latch_select),
        .clear(diag_read),
        .flag(power_over_flag)
    );

    // Trim status sits apart from the limit flags and never self-clears
    alb_trim_check u_trim (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .checksum_error(checksum_error),
        .trim_checksum_ok(trim_checksum_ok)
    );

    // Diagnostic status view; other bits belong to logic outside this bank
    always_comb begin
        diag_alert_status = '0;
        diag_alert_status[`ALB_DIAG_TEMP] = temp_over_flag;
        diag_alert_status[`ALB_DIAG_SHOV] = shunt_over_flag;
        diag_alert_status[`ALB_DIAG_SHUV] = shunt_under_flag;
        diag_alert_status[`ALB_DIAG_BUSOV] = bus_over_flag;
        diag_alert_status[`ALB_DIAG_BUSUV] = bus_under_flag;
        diag_alert_status[`ALB_DIAG_POWOV] = power_over_flag;
        diag_alert_status[`ALB_DIAG_MEM] = trim_checksum_ok;
    end
endmodule : alb_limit_bank

// file: pkg/alb_params.svh
// Register map, reset values and field positions for the alert limit bank
`ifndef ALB_PARAMS_SVH
`define ALB_PARAMS_SVH

`define ALB_ADDR_W 8
`define ALB_OFS_DIAG 8'h0B
`define ALB_OFS_SHUNT_HI 8'h0C
`define ALB_OFS_SHUNT_LO 8'h0D
`define ALB_OFS_BUS_HI 8'h0E
`define ALB_OFS_BUS_LO 8'h0F
`define ALB_OFS_TEMP 8'h10
`define ALB_OFS_POWER 8'h11

`define ALB_RST_SHUNT_HI 16'h7FFF
`define ALB_RST_SHUNT_LO 16'h8000
`define ALB_RST_BUS_HI 15'h7FFF
`define ALB_RST_BUS_LO 15'h0000
`define ALB_RST_TEMP 12'h7FF
`define ALB_RST_POWER 16'hFFFF

`define ALB_BUS_W 15
`define ALB_TEMP_W 12
`define ALB_TEMP_LSB 4
`define ALB_PWR_W 24
`define ALB_PWR_SHIFT 8

`define ALB_DIAG_TEMP 7
`define ALB_DIAG_SHOV 6
`define ALB_DIAG_SHUV 5
`define ALB_DIAG_BUSOV 4
`define ALB_DIAG_BUSUV 3
`define ALB_DIAG_POWOV 2
`define ALB_DIAG_MEM 0

`endif

// file: pkg/alb_pkg.sv
// Types shared by the alert limit bank
package alb_pkg;
    typedef enum logic [1:0] {
        ALB_CMP_GT,
        ALB_CMP_LT
    } alb_cmp_t;
endpackage : alb_pkg

// file: core/alb_limit_cmp.sv
// One limit comparator with sticky or live flag
`timescale 1ns/10ps
module alb_limit_cmp #(
    parameter int W = 16,
    parameter bit SIGNED_CMP = 1'b1,
    parameter alb_pkg::alb_cmp_t DIR = alb_pkg::ALB_CMP_GT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Sample and limit
    input wire logic sample_valid,
    input wire logic [W-1:0] sample,
    input wire logic [W-1:0] limit,
    // Flag control
    input wire logic latch_mode,
    input wire logic clear,
    output logic flag
);
    logic hit;

    always_comb begin
        if (SIGNED_CMP) begin
            if (DIR == alb_pkg::ALB_CMP_GT) begin
                hit = $signed(sample) > $signed(limit);
            end else begin
                hit = $signed(sample) < $signed(limit);
            end
        end else begin
            if (DIR == alb_pkg::ALB_CMP_GT) begin
                hit = sample > limit;
            end else begin
                hit = sample < limit;
            end
        end
    end

    // Set wins over a read clear so no event is lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (sample_valid) begin
            if (latch_mode) begin
                flag <= hit | (flag & ~clear);
            end else begin
                flag <= hit;
            end
        end else if (latch_mode && clear) begin
            flag <= 1'b0;
        end
    end
endmodule : alb_limit_cmp

// file: core/alb_trim_check.sv
// Trim memory checksum status holder
`timescale 1ns/10ps
module alb_trim_check (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Checksum result from trim loader
    input wire logic checksum_error,
    output logic trim_checksum_ok
);
    // Error is sticky until reset; the trim image does not change at run time
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_checksum_ok <= 1'b1;
        end else if (checksum_error) begin
            trim_checksum_ok <= 1'b0;
        end
    end
endmodule : alb_trim_check

// file: verif/alb_limit_bank_monitor.sv
// Assertion checker for the alert limit bank
`timescale 1ns/10ps
module alb_limit_bank_monitor #(
    parameter int DATA_W = 16
) (
    // Clock, reset and register port
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Modes, results and flags
    input wire logic alert_latch_select,
    input wire logic averaged_alert_select,
    input wire logic raw_valid,
    input wire logic avg_valid,
    input wire logic [23:0] raw_power,
    input wire logic checksum_error,
    input wire logic shunt_over_flag,
    input wire logic power_over_flag,
    input wire logic trim_checksum_ok,
    input wire logic [DATA_W-1:0] diag_alert_status
);
    logic [15:0] pwr_q;
    logic live;
    logic diag_rd;
    assign live = raw_valid && !averaged_alert_select && !alert_latch_select;
    assign diag_rd = reg_rd && reg_addr == 8'h0b;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Shadow ceiling so the power compare is predicted from ports alone
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= 16'hffff;
        end else if (reg_wr && reg_addr == 8'h11) begin
            pwr_q <= reg_wdata[15:0];
        end
    end
    trim_drop_a: assert property (
        checksum_error |=> (!trim_checksum_ok)[*3] ##0 !diag_alert_status[0])
        else $error("trim status kept high");
    bus_rsvd_a: assert property (
        reg_rd && reg_addr inside {8'h0e, 8'h0f} |=> !reg_rdata[15])
        else $error("bus limit bit 15 set");
    temp_rsvd_a: assert property (
        reg_rd && reg_addr == 8'h10 |=> reg_rdata[3:0] == 4'h0)
        else $error("temp limit low bits set");
    pwr_over_a: assert property (
        live && raw_power[23:8] > pwr_q |=> power_over_flag)
        else $error("power over missed");
    pwr_under_a: assert property (
        live && raw_power[23:8] <= pwr_q |=> !power_over_flag)
        else $error("power over false");
    latch_hold_a: assert property (
        alert_latch_select && shunt_over_flag && !diag_rd |=> shunt_over_flag)
        else $error("latched flag lost");
    latch_clr_a: assert property (
        alert_latch_select && diag_rd && !raw_valid && !avg_valid
        |=> diag_alert_status[7:2] == 6'h00) else $error("flags not cleared");
    avg_ignore_a: assert property (
        averaged_alert_select && !alert_latch_select && !avg_valid
        |=> $stable(shunt_over_flag)) else $error("raw sample not ignored");
    cover property (live && power_over_flag);
    cover property (alert_latch_select && diag_rd && shunt_over_flag);
    cover property (averaged_alert_select && avg_valid);
endmodule : alb_limit_bank_monitor

bind alb_limit_bank alb_limit_bank_monitor #(.DATA_W(DATA_W))
    alb_limit_bank_monitor_i (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .alert_latch_select(alert_latch_select),
    .averaged_alert_select(averaged_alert_select),
    .raw_valid(raw_valid),
    .avg_valid(avg_valid),
    .raw_power(raw_power),
    .checksum_error(checksum_error),
    .shunt_over_flag(shunt_over_flag),
    .power_over_flag(power_over_flag),
    .trim_checksum_ok(trim_checksum_ok),
    .diag_alert_status(diag_alert_status)
);

// file: verif/alb_host_model.sv
// Host model that drives the register port
`timescale 1ns/10ps
module alb_host_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [15:0] reg_wdata = 16'h0000,
    input wire logic [15:0] reg_rdata
);
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Stale data turns over so it cannot pass for a fresh word
        reg_wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask : rd
endmodule : alb_host_model

// file: verif/alb_limit_bank_tb_top.sv
// Self-checking bench for the alert limit bank
`timescale 1ns/10ps
module alb_limit_bank_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, diag, d;
    logic [5:0] flg;
    logic lat = 1'b0, avs = 1'b0, rv = 1'b0, av = 1'b0, cerr = 1'b0;
    logic [2:0] mode = 3'b000;
    logic [15:0] sh = 16'h0000, bs = 16'h0000;
    logic [11:0] tp = 12'h000;
    logic [23:0] pw = 24'h00_0000;
    logic [15:0] a_sh = 16'h0000, a_bs = 16'h0000;
    logic [11:0] a_tp = 12'h000;
    logic [23:0] a_pw = 24'h00_0000;
    logic tok;
    int err_count = 0, check_count = 0;
    localparam logic [15:0] r_tab [6] = '{16'h7fff, 16'h8000, 16'h7fff,
        16'h0000, 16'h7ff0, 16'hffff};
    localparam logic [15:0] o_tab [6] = '{16'hffff, 16'hffff, 16'h7fff,
        16'h7fff, 16'hfff0, 16'hffff};
    localparam logic [15:0] s_tab [6] = '{16'h0064, 16'hff9c, 16'h03e8,
        16'h000a, 16'h0c80, 16'h0010};
    always #10 ref_clk = ~ref_clk;
    alb_limit_bank alb_limit_bank_i (
        .ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .shunt_range_select(avs), .alert_latch_select(lat),
        .averaged_alert_select(avs), .raw_valid(rv), .raw_shunt(sh),
        .raw_bus(bs), .raw_die_temp(tp), .raw_power(pw), .avg_valid(av),
        .avg_shunt(a_sh), .avg_bus(a_bs), .avg_die_temp(a_tp),
        .avg_power(a_pw),
        .checksum_error(cerr), .temp_over_flag(flg[5]),
        .shunt_over_flag(flg[4]), .shunt_under_flag(flg[3]),
        .bus_over_flag(flg[2]), .bus_under_flag(flg[1]),
        .power_over_flag(flg[0]), .trim_checksum_ok(tok),
        .diag_alert_status(diag)
    );
    alb_host_model alb_host_model_i (
        .ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
    );
    task automatic chk(input string w, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", w, e, g);
            err_count++;
        end
    endtask : chk
    // Mode bits go out with the sample so both land on one edge
    task automatic smp(input logic [15:0] s, b, input logic [11:0] t,
        input logic [23:0] p, input logic [5:0] ex);
        @(posedge ref_clk);
        // Unused source gets zeros, which would trip other flags if taken
        if (mode[0]) begin
            {a_sh, a_bs, a_tp, a_pw} <= {s, b, t, p};
            {sh, bs, tp, pw} <= '0;
        end else begin
            {sh, bs, tp, pw} <= {s, b, t, p};
            {a_sh, a_bs, a_tp, a_pw} <= '0;
        end
        {lat, avs} <= mode[2:1];
        {rv, av} <= {!mode[0], mode[0]};
        @(posedge ref_clk);
        {rv, av} <= 2'b00;
        @(negedge ref_clk);
        chk("flags", {10'h000, ex}, {10'h000, flg});
    endtask : smp
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            alb_host_model_i.rd(8'h0c + 8'(i), d);
            chk("reset", r_tab[i], d);
            alb_host_model_i.wr(8'h0c + 8'(i), 16'hffff);
            alb_host_model_i.rd(8'h0c + 8'(i), d);
            chk("ones", o_tab[i], d);
            alb_host_model_i.wr(8'h0c + 8'(i), s_tab[i]);
        end
        alb_host_model_i.rd(8'h12, d);
        chk("unmapped", 16'h0000, d);
        smp(16'h0064, 16'h03e8, 12'h0c8, 24'h00_10ff, 6'h00);
        smp(16'h0065, 16'h03e9, 12'h0c9, 24'h00_1100, 6'h35);
        smp(16'hff9b, 16'h0009, 12'hffb, 24'h00_0000, 6'h0a);
        smp(16'h0000, 16'h8000, 12'h000, 24'hff_ffff, 6'h05);
        alb_host_model_i.wr(8'h0c, 16'hffce);
        alb_host_model_i.wr(8'h0d, 16'hff38);
        smp(16'h0000, 16'h01f4, 12'h000, 24'h00_0000, 6'h10);
        alb_host_model_i.rd(8'h0b, d);
        chk("live status", 16'h0041, d);
        chk("kept", 16'h0041, diag);
        mode = 3'b001;
        smp(16'h0065, 16'h03e9, 12'h0c9, 24'h00_1100, 6'h10);
        mode = 3'b010;
        smp(16'h0065, 16'h03e9, 12'h0c9, 24'h00_1100, 6'h10);
        mode = 3'b011;
        smp(16'h0065, 16'h03e9, 12'h0c9, 24'h00_1100, 6'h35);
        mode = 3'b100;
        smp(16'h0065, 16'h03e9, 12'h0c9, 24'h00_1100, 6'h35);
        smp(16'hff9c, 16'h01f4, 12'h000, 24'h00_0000, 6'h35);
        alb_host_model_i.rd(8'h0b, d);
        chk("status", 16'h00d5, d);
        chk("cleared", 16'h0001, diag);
        @(posedge ref_clk);
        cerr <= 1'b1;
        @(posedge ref_clk);
        cerr <= 1'b0;
        @(negedge ref_clk);
        chk("trim", 16'h0000, diag);
        chk("trim ok", 16'h0000, {15'h0000, tok});
        // Mid-run reset must bring back the trim status and the shunt high limit
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk("trim back", 16'h0001, diag);
        chk("ok back", 16'h0001, {15'h0000, tok});
        alb_host_model_i.rd(8'h0c, d);
        chk("limit back", 16'h7fff, d);
        tally_and_finish();
    end
endmodule : alb_limit_bank_tb_top
